//--- include/rss_pkg.sv
package rss_pkg;

  localparam int CLK_PERIOD_NS      = 25;
  localparam int SLOW_OSC_PERIOD_NS = 32000;
  localparam int SLOW_TICK_CYCLES   = SLOW_OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PLL_LOCK_NS        = 2000000;
  localparam int PLL_LOCK_CYCLES    = PLL_LOCK_NS / CLK_PERIOD_NS;
  localparam int BOR_QUALIFY_NS     = 1000;
  localparam int BOR_QUALIFY_CYCLES = (BOR_QUALIFY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int POWER_UP_TIMER_TICKS         = 2048;
  localparam int OST_OSC_CYCLES     = 1024;
  localparam int PIN_FILTER_CYCLES  = 8;

  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CAUSE  = 4'h1;

  localparam logic [1:0] BOR_MODE_OFF     = 2'h0;
  localparam logic [1:0] BOR_MODE_SOFT    = 2'h1;
  localparam logic [1:0] BOR_MODE_NOSLEEP = 2'h2;
  localparam logic [1:0] BOR_MODE_ON      = 2'h3;

  typedef enum logic [2:0] {
    ST_POR, ST_BOR, ST_HOLD, ST_POWER_UP_TIMER, ST_OST, ST_PLL, ST_RUN
  } rss_state_t;

  typedef struct packed {
    logic irqLevelEnable;
    logic softBrownoutEnable;
    logic reserved;
    logic softResetFlag;
    logic watchdogTripFlag;
    logic sleepEntryFlag;
    logic powerOnFlag;
    logic brownoutFlag;
  } rss_status_t;

  typedef struct packed {
    logic por;
    logic pinNormal;
    logic pinManaged;
    logic watchdog;
    logic brownout;
    logic resetInstr;
    logic stackFull;
    logic stackUnderflow;
  } rss_cause_t;

  typedef struct packed {
    logic       pinResetEnable;
    logic [1:0] brownoutModeConfig;
    logic [1:0] brownoutLevelConfig;
    logic       powerUpTimerDisable;
    logic       crystalMode;
    logic       pllEnable;
  } rss_cfg_t;

  typedef struct packed {
    logic wdtTimeout;
    logic resetInstr;
    logic stackFull;
    logic stackUnderflow;
    logic watchdogClearInstr;
    logic sleepInstr;
    logic wakeOscStop;
  } rss_evt_t;

  localparam rss_status_t STATUS_POR = '{
    softResetFlag: 1'h1, watchdogTripFlag: 1'h1, sleepEntryFlag: 1'h1, default: 1'h0};
  localparam rss_cause_t CAUSE_POR = '{por: 1'h1, default: 1'h0};

endpackage

//--- hdl/rss_pin_filter.sv
`timescale 1ns/1ps
module rss_pin_filter #(
  parameter int MIN_LOW_CYCLES = rss_pkg::PIN_FILTER_CYCLES
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pinLevel,
  output logic      lowQualified
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       low;
  } rss_filt_t;

  localparam logic [7:0] LOW_LAST = 8'(MIN_LOW_CYCLES - 1);

  rss_filt_t q;
  rss_filt_t d;

  // low must persist for the full width before it counts
  always_comb begin
    d = q;
    if (pinLevel) begin
      d.cnt = '0;
      d.low = 1'h0;
    end else if (q.cnt == LOW_LAST) begin
      d.low = 1'h1; // see [R26]
    end else begin
      d.cnt = q.cnt + 8'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lowQualified = q.low;

endmodule

//--- hdl/rss_reset_sequencer.sv
// Contract
// [R1] eight reset sources are accepted and told apart
// [R2] status bit 7 is read/write interrupt priority enable; bit 5 reads zero
// [R3] bit 6 enables brown-out only in mode 01; otherwise inert, reads zero
// [R4] bit 6 resets to one when operative, else zero
// [R5] reset instruction clears bit 4; set by power-on or software write
// [R6] bit 3 read-only: set by power-up, watchdog clear, sleep; cleared by time-out
// [R7] bit 2 read-only: set by power-up or watchdog clear; cleared by sleep
// [R8] bit 1 cleared by every power-on reset; only software sets it
// [R9] with brown-out enabled, bit 0 cleared by brown-out or power-on
// [R10] pin held low resets device; short low pulses filtered out
// [R11] pin never driven low by any internal reset
// [R12] pin reset disabled: pin ignored for reset, acts as digital input
// [R13] supply-good rising makes a power-on reset pulse
// [R14] qualified low supply resets; stays in reset until supply recovers
// [R15] timer runs after brown-out recovery; new brown-out restarts it
// [R16] brown-out and power-up timer enabled independently
// [R17] mode 10: detection on in run and idle, off during sleep
// [R18] mode 11 always on, mode 00 always off, software cannot change
// [R19] threshold comes only from level config, never from software
// [R20] power-up timer: 11-bit count of 2048 slow oscillator periods
// [R21] power-up timer enabled when its disable bit is zero
// [R22] 1024 oscillator cycles after delay, crystal mode, power-on or wake
// [R23] pll lock delay of 2 ms follows oscillator start-up
// [R24] power-up delay starts after power-on pulse, then oscillator delay
// [R25] core reset held while any source or timer active; released synchronously (wake start-up timers run with core released, clockHold set instead)
// [R26] pin filter minimum low width is a parameter
`timescale 1ns/1ps
module rss_reset_sequencer #(
  parameter int unsigned PLL_LOCK_CYCLES  = rss_pkg::PLL_LOCK_CYCLES,
  parameter int unsigned SLOW_TICK_CYCLES = rss_pkg::SLOW_TICK_CYCLES
) (
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [3:0]        addr,
  input  wire logic [7:0]        wrData,
  input  wire logic              wrStrobe,
  input  wire logic              rdStrobe,
  output logic [7:0]             rdData,
  input  wire rss_pkg::rss_cfg_t cfg,
  input  wire rss_pkg::rss_evt_t evt,
  input  wire logic              supplyGood,
  input  wire logic              belowBrownout,
  input  wire logic              inSleep,
  input  wire logic              inPowerManaged,
  input  wire logic              extResetPin_n,
  input  wire logic              oscIn,
  output logic                   coreReset_n,
  output logic                   clockHold,
  output logic                   brownoutDetectEn,
  output logic [1:0]             brownoutLevelSel,
  output logic                   irqLevelEnable,
  output logic                   pinDigitalIn,
  output logic                   extResetPinOe,
  output rss_pkg::rss_cause_t    resetCause
);

  typedef struct packed {
    rss_pkg::rss_state_t  st;
    logic                 porSeq;
    logic                 wake;
    logic [16:0]          cnt;
    logic [10:0]          pwrtCnt;
    logic [10:0]          tickDiv;
    logic [5:0]           qual;
    logic                 borTrip;
    logic                 pinHoldPrev;
    logic                 prevOsc;
    rss_pkg::rss_status_t status;
    rss_pkg::rss_cause_t  cause;
    logic [7:0]           rdData;
    logic                 coreReset_n;
    logic                 clockHold;
    logic                 brownout_mode_config;
    logic [1:0]           levelSel;
    logic                 pinIn;
    logic                 pinOe;
  } rss_seq_t;

  localparam logic [16:0] PLL_LAST  = 17'(PLL_LOCK_CYCLES - 1);
  localparam logic [16:0] OST_LAST  = 17'(rss_pkg::OST_OSC_CYCLES - 1);
  localparam logic [10:0] TICK_LAST = 11'(SLOW_TICK_CYCLES - 1);
  localparam logic [10:0] POWER_UP_TIMER_LAST = 11'(rss_pkg::POWER_UP_TIMER_TICKS - 1);
  localparam logic [5:0]  QUAL_LAST = 6'(rss_pkg::BOR_QUALIFY_CYCLES - 1);
  localparam rss_seq_t    RST_SEQ   = '{
    st: rss_pkg::ST_POR, status: rss_pkg::STATUS_POR, cause: rss_pkg::CAUSE_POR,
    default: '0};

  rss_seq_t             q;
  rss_seq_t             d;
  rss_pkg::rss_status_t wrStatus;
  rss_pkg::rss_status_t rdView;
  logic                 pinLow;
  logic                 pinHold;
  logic                 brownout_mode_config;
  logic                 slowTick;
  logic                 oscRise;
  logic                 softRst;
  logic                 modeSoft;

  assign wrStatus = wrData;
  assign rdView   = rdData;
  assign modeSoft = cfg.brownoutModeConfig == rss_pkg::BOR_MODE_SOFT;

  rss_pin_filter #(
    .MIN_LOW_CYCLES (rss_pkg::PIN_FILTER_CYCLES)
  ) u_filter (
    .clock        (clock),
    .rst_n        (rst_n),
    .pinLevel     (extResetPin_n),
    .lowQualified (pinLow)
  );

  function automatic rss_pkg::rss_state_t afterPwrt(input logic por);
    if (por && cfg.crystalMode) begin
      afterPwrt = rss_pkg::ST_OST; // see [R22] [R24]
    end else if (por && cfg.pllEnable) begin
      afterPwrt = rss_pkg::ST_PLL;
    end else begin
      afterPwrt = rss_pkg::ST_RUN;
    end
  endfunction

  function automatic rss_pkg::rss_state_t startSeq(input logic por);
    if (!cfg.powerUpTimerDisable) begin
      startSeq = rss_pkg::ST_POWER_UP_TIMER; // see [R21] [R16]
    end else begin
      startSeq = afterPwrt(por);
    end
  endfunction

  always_comb begin
    d             = q;
    d.prevOsc     = oscIn;
    pinHold       = cfg.pinResetEnable && pinLow; // see [R10] [R12]
    d.pinHoldPrev = pinHold;
    brownout_mode_config = (cfg.brownoutModeConfig == rss_pkg::BOR_MODE_ON) ||
            (cfg.brownoutModeConfig == rss_pkg::BOR_MODE_NOSLEEP && !inSleep) ||
            (modeSoft && q.status.softBrownoutEnable); // see [R3] [R17] [R18]
    slowTick = (q.st == rss_pkg::ST_POWER_UP_TIMER) && (q.tickDiv == TICK_LAST);
    oscRise  = oscIn && !q.prevOsc;
    softRst  = evt.resetInstr || evt.stackFull || evt.stackUnderflow ||
               (evt.wdtTimeout && !inSleep);

    // brown-out qualifier
    if (!brownout_mode_config || !belowBrownout) begin
      d.qual    = '0;
      d.borTrip = 1'h0;
    end else if (q.qual == QUAL_LAST) begin
      d.borTrip = 1'h1; // see [R14]
    end else begin
      d.qual = q.qual + 6'h01;
    end

    // slow oscillator tick divider
    if (slowTick || q.st != rss_pkg::ST_POWER_UP_TIMER) begin
      d.tickDiv = '0;
    end else begin
      d.tickDiv = q.tickDiv + 11'h001;
    end

    // software write
    if (wrStrobe && addr == rss_pkg::REG_STATUS) begin
      d.status.irqLevelEnable = wrStatus.irqLevelEnable; // see [R2]
      if (modeSoft) begin
        d.status.softBrownoutEnable = wrStatus.softBrownoutEnable; // see [R3]
      end
      d.status.softResetFlag = wrStatus.softResetFlag;
      d.status.powerOnFlag   = wrStatus.powerOnFlag;
      d.status.brownoutFlag  = wrStatus.brownoutFlag;
    end

    // hardware events override a same-cycle write
    if (evt.watchdogClearInstr) begin
      d.status.watchdogTripFlag = 1'h1; // see [R6]
      d.status.sleepEntryFlag   = 1'h1; // see [R7]
    end
    if (evt.sleepInstr) begin
      d.status.watchdogTripFlag = 1'h1; // see [R6]
      d.status.sleepEntryFlag   = 1'h0; // see [R7]
    end
    if (pinHold && !q.pinHoldPrev) begin
      d.cause = '0;
      if (inSleep || inPowerManaged) begin
        d.cause.pinManaged        = 1'h1; // see [R1]
        d.status.watchdogTripFlag = 1'h1;
        if (inSleep) begin
          d.status.sleepEntryFlag = 1'h0;
        end
      end else begin
        d.cause.pinNormal = 1'h1; // see [R1]
      end
    end
    if (evt.wdtTimeout) begin
      d.status.watchdogTripFlag = 1'h0; // see [R6]
      if (inSleep) begin
        d.status.sleepEntryFlag = 1'h0;
      end
    end
    if (evt.resetInstr) begin
      d.status.softResetFlag = 1'h0; // see [R5]
    end
    if (softRst) begin
      d.cause                = '0;
      d.cause.watchdog       = evt.wdtTimeout && !inSleep; // see [R1]
      d.cause.resetInstr     = evt.resetInstr;
      d.cause.stackFull      = evt.stackFull;
      d.cause.stackUnderflow = evt.stackUnderflow;
    end
    if (d.borTrip && !q.borTrip) begin
      d.status.softResetFlag    = 1'h1;
      d.status.watchdogTripFlag = 1'h1;
      d.status.sleepEntryFlag   = 1'h1;
      d.status.brownoutFlag     = 1'h0; // see [R9]
      d.cause                   = '0;
      d.cause.brownout          = 1'h1;
    end

    // sequencer
    case (q.st)
      rss_pkg::ST_POR: begin
        d.status                    = rss_pkg::STATUS_POR; // see [R8] [R9]
        d.status.softBrownoutEnable = modeSoft; // see [R4]
        d.cause                     = rss_pkg::CAUSE_POR;
        d.porSeq                    = 1'h1;
        d.wake                      = 1'h0;
        if (supplyGood) begin
          d.st = startSeq(1'h1); // see [R13] [R24]
        end
      end
      rss_pkg::ST_BOR: begin
        if (!d.borTrip) begin
          d.st = startSeq(1'h0); // see [R15]
        end
      end
      rss_pkg::ST_HOLD: begin
        d.st = rss_pkg::ST_RUN;
      end
      rss_pkg::ST_POWER_UP_TIMER: begin
        if (slowTick) begin
          if (q.pwrtCnt == POWER_UP_TIMER_LAST) begin
            d.st = afterPwrt(q.porSeq); // see [R20]
          end else begin
            d.pwrtCnt = q.pwrtCnt + 11'h001;
          end
        end
      end
      rss_pkg::ST_OST: begin
        if (oscRise) begin
          if (q.cnt == OST_LAST) begin
            d.st = cfg.pllEnable ? rss_pkg::ST_PLL : rss_pkg::ST_RUN; // see [R23]
          end else begin
            d.cnt = q.cnt + 17'h0_0001;
          end
        end
      end
      rss_pkg::ST_PLL: begin
        if (q.cnt == PLL_LAST) begin
          d.st = rss_pkg::ST_RUN; // see [R23]
        end else begin
          d.cnt = q.cnt + 17'h0_0001;
        end
      end
      default: begin
        d.porSeq = 1'h0;
        d.wake   = 1'h0;
        if (evt.wakeOscStop && cfg.crystalMode) begin
          d.st   = rss_pkg::ST_OST; // see [R22]
          d.wake = 1'h1;
        end
      end
    endcase

    // priority: power-on, brown-out, then core-driven resets
    if (!supplyGood) begin
      d.st   = rss_pkg::ST_POR; // see [R13]
      d.wake = 1'h0;
    end else if (d.borTrip && q.st != rss_pkg::ST_POR) begin
      d.st     = rss_pkg::ST_BOR; // see [R15]
      d.porSeq = 1'h0;
      d.wake   = 1'h0;
    end else if (softRst && q.st == rss_pkg::ST_RUN) begin
      d.st   = rss_pkg::ST_HOLD;
      d.wake = 1'h0; // see [R25]
    end

    if (d.st != q.st) begin
      d.cnt     = '0;
      d.pwrtCnt = '0; // see [R15]
    end

    d.coreReset_n = !pinHold && !d.borTrip &&
                    (d.st == rss_pkg::ST_RUN || d.wake); // see [R25]
    d.clockHold   = d.wake && d.st != rss_pkg::ST_RUN;
    d.brownout_mode_config       = brownout_mode_config;
    d.levelSel    = cfg.brownoutLevelConfig; // see [R19]
    d.pinIn       = cfg.pinResetEnable ? 1'h1 : extResetPin_n; // see [R12]
    d.pinOe       = 1'h0; // see [R11]

    // read port, data valid only the cycle after the strobe
    d.rdData = '0;
    if (rdStrobe && addr == rss_pkg::REG_STATUS) begin
      d.rdData                    = q.status;
      d.rdData[$bits(rdView) - 3] = 1'h0; // see [R2]
      d.rdData[$bits(rdView) - 2] = q.status.softBrownoutEnable && modeSoft; // see [R3]
    end else if (rdStrobe && addr == rss_pkg::REG_CAUSE) begin
      d.rdData = q.cause; // see [R1]
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      q <= RST_SEQ;
    end else begin
      q <= d;
    end
  end

  assign rdData           = q.rdData;
  assign coreReset_n      = q.coreReset_n;
  assign clockHold        = q.clockHold;
  assign brownoutDetectEn = q.brownout_mode_config;
  assign brownoutLevelSel = q.levelSel;
  assign irqLevelEnable   = q.status.irqLevelEnable;
  assign pinDigitalIn     = q.pinIn;
  assign extResetPinOe    = q.pinOe;
  assign resetCause       = q.cause;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  property p_por_flag;
    (q.st == rss_pkg::ST_POR) |=> !q.status.powerOnFlag && !q.status.brownoutFlag;
  endproperty
  a_por_flag: assert property (p_por_flag) else $error("power-on flag not cleared"); // see [R8]

  property p_ri_clear;
    evt.resetInstr && supplyGood && !belowBrownout && q.st == rss_pkg::ST_RUN
      |=> !q.status.softResetFlag ##1 q.st == rss_pkg::ST_RUN;
  endproperty
  a_ri_clear: assert property (p_ri_clear) else $error("reset instruction mishandled"); // see [R5]

  property p_wdt_trip;
    evt.wdtTimeout && supplyGood && !belowBrownout && q.st == rss_pkg::ST_RUN
      |=> !q.status.watchdogTripFlag;
  endproperty
  a_wdt_trip: assert property (p_wdt_trip) else $error("watchdog flag not cleared"); // see [R6]

  property p_sleep_pd;
    evt.sleepInstr && !evt.watchdogClearInstr && supplyGood && !belowBrownout
      && q.st == rss_pkg::ST_RUN |=> !q.status.sleepEntryFlag && q.status.watchdogTripFlag;
  endproperty
  a_sleep_pd: assert property (p_sleep_pd) else $error("sleep flags wrong"); // see [R7]

  property p_sbo_read;
    rdStrobe && addr == rss_pkg::REG_STATUS && !modeSoft
      |=> !rdView.softBrownoutEnable && !rdView.reserved;
  endproperty
  a_sbo_read: assert property (p_sbo_read) else $error("inert enable reads set"); // see [R3]

  property p_irq_level_enable;
    wrStrobe && addr == rss_pkg::REG_STATUS |=> irqLevelEnable == $past(wrData[7]);
  endproperty
  a_irq_level_enable: assert property (p_irq_level_enable) else $error("priority enable not written"); // see [R2]

  property p_pin_reset;
    pinLow && cfg.pinResetEnable |=> !coreReset_n;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("pin reset not applied"); // see [R10]

  property p_pin_off;
    !cfg.pinResetEnable |=> pinDigitalIn == $past(extResetPin_n) && !extResetPinOe;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin not a plain input"); // see [R12]

  property p_bor_qual;
    q.qual == QUAL_LAST && brownout_mode_config && belowBrownout |=> q.borTrip ##0 !coreReset_n;
  endproperty
  a_bor_qual: assert property (p_bor_qual) else $error("brown-out not qualified"); // see [R14]

  property p_power_up_timer_restart;
    $rose(q.borTrip) && $past(q.st) == rss_pkg::ST_POWER_UP_TIMER && supplyGood
      |-> q.st == rss_pkg::ST_BOR && q.pwrtCnt == '0 && !q.status.brownoutFlag;
  endproperty
  a_power_up_timer_restart: assert property (p_power_up_timer_restart) else $error("timer not restarted"); // see [R15]

  property p_core_hold;
    ((q.st != rss_pkg::ST_RUN && !q.wake) |-> !coreReset_n) and
      ((pinHold || !supplyGood) |=> !coreReset_n);
  endproperty
  a_core_hold: assert property (p_core_hold) else $error("core released early"); // see [R25]

  property p_mode_nosleep;
    cfg.brownoutModeConfig == rss_pkg::BOR_MODE_NOSLEEP |=> brownoutDetectEn == !$past(inSleep);
  endproperty
  a_mode_nosleep: assert property (p_mode_nosleep) else $error("sleep mode enable wrong"); // see [R17]

  c_power_up_timer_done: cover property (q.st == rss_pkg::ST_POWER_UP_TIMER ##1 q.st == rss_pkg::ST_RUN);
  c_bor_trip: cover property ($rose(q.borTrip));
  c_wake_ost: cover property (q.wake && q.st == rss_pkg::ST_OST);
  c_pin_rst: cover property ($fell(coreReset_n) && pinHold);

endmodule

//--- bench/rss_far_side.sv
`timescale 1ns/1ps
module rss_far_side (
  input  wire logic clock,
  input  wire logic supplyOn,
  input  wire logic sag,
  input  wire logic pinHold,
  output logic      supplyGood,
  output logic      belowBrownout,
  output logic      extResetPin_n,
  output logic      oscIn
);
  // supply comparators follow the commanded rail
  assign supplyGood    = supplyOn;
  assign belowBrownout = sag | ~supplyOn;
  // pulled-up pin, only the outside world pulls it low
  assign extResetPin_n = ~pinHold;
  // crystal runs free at half the system rate
  initial oscIn = 1'b0;
  always @(posedge clock) oscIn <= ~oscIn;
endmodule

//--- bench/rss_reset_sequencer_tb_top.sv
`timescale 1ns/1ps
module rss_reset_sequencer_tb_top;
  localparam int ST   = 4;
  localparam int PL   = 16;
  localparam int POWER_UP_TIMER = 2048 * ST;
  logic                clock          = 1'b0;
  logic                rst_n          = 1'b0;
  logic [3:0]          addr           = 4'h0;
  logic [7:0]          wrData         = 8'h00;
  logic                wrStrobe       = 1'b0;
  logic                rdStrobe       = 1'b0;
  // pin on, soft brown-out mode, timers, crystal and pll on
  rss_pkg::rss_cfg_t   cfg            = 8'hB3;
  rss_pkg::rss_evt_t   evt            = 7'h00;
  logic                supplyOn       = 1'b1;
  logic                sag            = 1'b0;
  logic                pinHold        = 1'b0;
  logic                inSleep        = 1'b0;
  logic                inPowerManaged = 1'b0;
  logic [31:0]         seed           = 32'h0000_9818;
  logic [7:0]          cz [4]         = '{8'h10, 8'h04, 8'h02, 8'h01};
  int                  fails          = 0;
  int                  cmp_count      = 0;
  logic [7:0]          rdData;
  logic                supplyGood, belowBrownout, extResetPin_n, oscIn;
  logic                coreReset_n, clockHold, brownoutDetectEn, irqLevelEnable;
  logic                pinDigitalIn, extResetPinOe;
  logic [1:0]          brownoutLevelSel;
  rss_pkg::rss_cause_t resetCause;

  always #12.5 clock = ~clock;

  rss_far_side u_rss_far_side (.clock(clock), .supplyOn(supplyOn), .sag(sag),
    .pinHold(pinHold), .supplyGood(supplyGood), .belowBrownout(belowBrownout),
    .extResetPin_n(extResetPin_n), .oscIn(oscIn));

  rss_reset_sequencer #(.PLL_LOCK_CYCLES(PL), .SLOW_TICK_CYCLES(ST)) u_rss_reset_sequencer (
    .clock(clock), .rst_n(rst_n), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .cfg(cfg), .evt(evt), .supplyGood(supplyGood),
    .belowBrownout(belowBrownout), .inSleep(inSleep), .inPowerManaged(inPowerManaged),
    .extResetPin_n(extResetPin_n), .oscIn(oscIn), .coreReset_n(coreReset_n),
    .clockHold(clockHold), .brownoutDetectEn(brownoutDetectEn),
    .brownoutLevelSel(brownoutLevelSel), .irqLevelEnable(irqLevelEnable),
    .pinDigitalIn(pinDigitalIn), .extResetPinOe(extResetPinOe), .resetCause(resetCause));

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  // software write in soft mode: bits 3,2 untouched, bit 5 reads zero
  function automatic logic [7:0] afterWr(input logic [7:0] cur, input logic [7:0] w);
    return {w[7:6], 1'b0, w[4], cur[3:2], w[1:0]};
  endfunction

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wrData <= d;
    wrStrobe <= 1'b1;
    @(posedge clock);
    wrStrobe <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge clock);
    addr <= a;
    rdStrobe <= 1'b1;
    @(posedge clock);
    rdStrobe <= 1'b0;
    #1 chk(nm, rdData, e);
  endtask

  task automatic pulse(input rss_pkg::rss_evt_t e);
    @(posedge clock);
    evt <= e;
    @(posedge clock);
    evt <= 7'h00;
  endtask

  task automatic waitRel(output int n);
    n = 0;
    while (coreReset_n !== 1'b1 && n < 20000) begin
      @(posedge clock);
      #1 n++;
    end
    chk("released", coreReset_n, 1'b1);
  endtask

  task automatic stay(input int c, input logic v, input string nm);
    logic ok;
    ok = 1'b1;
    repeat (c) begin
      @(posedge clock);
      #1 if (coreReset_n !== v) ok = 1'b0;
    end
    chk(nm, ok, 1'b1);
  endtask

  task automatic pinRst(input logic [7:0] c);
    int n;
    pinHold <= 1'b1;
    repeat (20) @(posedge clock);
    #1 chk("pin reset", coreReset_n, 1'b0);
    chk("pin output enable", extResetPinOe, 1'b0);
    rd(4'h1, c, "pin cause");
    pinHold <= 1'b0;
    waitRel(n);
  endtask

  initial begin
    repeat (60000) @(posedge clock);
    fails++;
    final_report();
  end

  initial begin
    int n;
    logic [7:0] st;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    #1 chk("held at release", coreReset_n, 1'b0);
    waitRel(n);
    chk("power-up length", n >= POWER_UP_TIMER + 2048 + PL - 4 && n <= POWER_UP_TIMER + 2048 + PL + 40, 1);
    st = 8'h5C;
    rd(4'h0, st, "status after power-on");
    rd(4'h1, 8'h80, "cause after power-on");
    pulse(7'h01);
    @(posedge clock);
    #1 chk("clock hold on wake", clockHold, 1'b1);
    n = 0;
    while (clockHold === 1'b1 && n < 3000) begin
      @(posedge clock);
      #1 n++;
    end
    chk("wake delay", n >= 2040 && n <= 2048 + PL + 40, 1'b1);
    chk("core kept on wake", coreReset_n, 1'b1);
    for (int k = 0; k < 24; k++) begin
      seed = xs(seed);
      wr(4'h0, seed[7:0]);
      st = afterWr(st, seed[7:0]);
      rd(4'h0, st, "status write");
      chk("priority enable", irqLevelEnable, st[7]);
      chk("soft detect", brownoutDetectEn, st[6]);
    end
    wr(4'h9, 8'hFF);
    rd(4'h9, 8'h00, "unmapped read");
    wr(4'h0, 8'h13);
    st = afterWr(st, 8'h13);
    pulse(7'h02);
    st[3:2] = 2'b10;
    rd(4'h0, st, "after sleep");
    pulse(7'h04);
    st[3:2] = 2'b11;
    rd(4'h0, st, "after watchdog clear");
    for (int k = 0; k < 4; k++) begin
      pulse(7'h40 >> k);
      #1 chk("soft reset low", coreReset_n, 1'b0);
      stay(3, 1'b1, "soft reset pulse");
      waitRel(n);
      if (k == 0) st[3] = 1'b0;
      if (k == 1) st[4] = 1'b0;
      rd(4'h1, cz[k], "soft cause");
      rd(4'h0, st, "soft status");
    end
    pinHold <= 1'b1;
    repeat (5) @(posedge clock);
    pinHold <= 1'b0;
    stay(12, 1'b1, "short pin pulse");
    pinRst(8'h40);
    rd(4'h0, st, "status after pin");
    inPowerManaged <= 1'b1;
    pinRst(8'h20);
    inPowerManaged <= 1'b0;
    st[3] = 1'b1;
    rd(4'h0, st, "status after managed pin");
    cfg.pinResetEnable <= 1'b0;
    pinHold <= 1'b1;
    stay(20, 1'b1, "pin ignored");
    chk("pin as input", pinDigitalIn, 1'b0);
    pinHold <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk("pin input high", pinDigitalIn, 1'b1);
    cfg.pinResetEnable <= 1'b1;
    wr(4'h0, 8'h13);
    st = 8'h1F;
    sag <= 1'b1;
    stay(60, 1'b1, "soft detect off");
    sag <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      cfg.brownoutLevelConfig <= k[1:0];
      repeat (2) @(posedge clock);
      #1 chk("level select", brownoutLevelSel, k[1:0]);
    end
    cfg.brownoutModeConfig <= 2'h2;
    inSleep <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk("off in sleep", brownoutDetectEn, 1'b0);
    inSleep <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk("on after sleep", brownoutDetectEn, 1'b1);
    cfg.brownoutModeConfig <= 2'h0;
    sag <= 1'b1;
    stay(60, 1'b1, "mode off ignores sag");
    sag <= 1'b0;
    cfg.brownoutModeConfig <= 2'h3;
    repeat (2) @(posedge clock);
    #1 chk("mode on", brownoutDetectEn, 1'b1);
    sag <= 1'b1;
    stay(30, 1'b1, "short sag");
    sag <= 1'b0;
    repeat (2) @(posedge clock);
    sag <= 1'b1;
    repeat (60) @(posedge clock);
    stay(50, 1'b0, "brown-out hold");
    rd(4'h1, 8'h08, "brown-out cause");
    chk("cause port", resetCause, 8'h08);
    rd(4'h0, 8'h1E, "brown-out flag");
    sag <= 1'b0;
    stay(4000, 1'b0, "timer holds");
    sag <= 1'b1;
    repeat (60) @(posedge clock);
    sag <= 1'b0;
    waitRel(n);
    chk("timer restarted", n >= POWER_UP_TIMER - 4 && n <= POWER_UP_TIMER + 60, 1'b1);
    cfg.powerUpTimerDisable <= 1'b1;
    sag <= 1'b1;
    repeat (60) @(posedge clock);
    sag <= 1'b0;
    waitRel(n);
    chk("timer bypassed", n <= 20, 1'b1);
    cfg <= 8'hA4;
    supplyOn <= 1'b0;
    repeat (10) @(posedge clock);
    #1 chk("power loss", coreReset_n, 1'b0);
    supplyOn <= 1'b1;
    waitRel(n);
    chk("fast power-up", n <= 20, 1'b1);
    rd(4'h0, 8'h5C, "status after power-on");
    rd(4'h1, 8'h80, "cause after power-on");
    final_report();
  end
endmodule
